// file: can_pkg.sv
package can_pkg;
  // register indexes on the plain port
  localparam logic [3:0] A_PIN_MODE = 4'h0;
  localparam logic [3:0] A_TIMING_ONE = 4'h1;
  localparam logic [3:0] A_TIMING_TWO = 4'h2;
  localparam logic [3:0] A_PRESCALER = 4'h3;
  localparam logic [3:0] A_MODULE_CFG = 4'h4;
  localparam logic [3:0] A_ERR_STATUS = 4'h5;
  localparam logic [3:0] A_TX_COUNT = 4'h6;
  localparam logic [3:0] A_RX_COUNT = 4'h7;
  // reset values
  localparam logic [7:0] MCR_RESET = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int MCR_HALT = 7;
  localparam int MCR_FREEZE = 6;
  localparam int MCR_TEST = 5;
  localparam int C0_BUSOFF_MASK = 7;
  localparam int C0_ERROR_MASK = 6;
  localparam int C1_ARB_ORDER = 7;
  localparam int C1_PROP_LSB = 0;
  localparam int C2_JUMP_LSB = 6;
  localparam int C2_PS1_LSB = 3;
  localparam int C2_PS2_LSB = 0;
  localparam int ES_PROC_LSB = 6;
  localparam int ES_STATE_LSB = 4;
  localparam int ES_SLOW = 3;
  localparam int ES_BUSOFF = 2;
  localparam int ES_ERROR = 1;
  // fault confinement figures
  localparam logic [7:0] ERR_STEP = 8'h08;
  localparam logic [7:0] PASSIVE_LEVEL = 8'h80;
  localparam logic [7:0] ACTIVE_LEVEL = 8'h7f;
  localparam logic [7:0] RX_PRESET_MIN = 8'h77;
  localparam logic [7:0] RX_PRESET_MAX = 8'h7f;
  localparam logic [7:0] RECOVERY_RUNS = 8'h80;
  localparam logic [3:0] RUN_LAST_BIT = 4'ha;
  localparam logic [3:0] SUSPEND_BITS = 4'h8;
  // timing figures
  localparam logic [1:0] PROC_ONE_CLOCK = 2'h3;
  localparam logic [1:0] PROC_OTHER = 2'h2;
  localparam logic [2:0] PS2_LATE_TX = 3'h2;
  localparam logic [12:0] SLOW_BIT_CLOCKS = 13'h00a;
  typedef enum logic [1:0] {
    ERR_ACTIVE = 2'b00,
    ERR_PASSIVE = 2'b01,
    BUS_OFF = 2'b10
  } fault_state_t;
endpackage

// file: can_bt_if.sv
interface can_bt_if;
  logic run;
  logic [7:0] prescale;
  logic [2:0] prop;
  logic [2:0] ps1;
  logic [2:0] ps2;
  logic [1:0] jump_width;
  logic rx;
  logic tq_en;
  logic sample;
  logic rx_bit;
  logic tx_point;
  modport timing (
    input run, prescale, prop, ps1, ps2, jump_width, rx,
    output tq_en, sample, rx_bit, tx_point
  );
  modport core (
    output run, prescale, prop, ps1, ps2, jump_width, rx,
    input tq_en, sample, rx_bit, tx_point
  );
endinterface

// file: can_bit_timing.sv
module can_bit_timing
  import can_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration and bus level
  can_bt_if.timing bt
);
  typedef enum logic [1:0] {
    SEG_SYNC = 2'b00,
    SEG_ONE = 2'b01,
    SEG_TWO = 2'b10
  } seg_t;
  seg_t seg_q;
  logic [7:0] div_q;
  logic [4:0] cnt_q;
  logic [4:0] len_q;
  logic rx_prev_q;
  logic edge_q;
  logic tq_q;
  logic sample_q;
  logic bit_q;
  logic txp_q;
  logic tick;
  logic [4:0] jump;
  logic [4:0] len1;
  logic [4:0] len2;
  logic [4:0] phase_err;
  logic [4:0] len_one;
  logic [4:0] len_two;
  logic at_sample;
  assign tick = bt.run && div_q == bt.prescale;
  assign jump = {3'h0, bt.jump_width} + 5'h01;
  assign len1 = {2'h0, bt.prop} + {2'h0, bt.ps1} + 5'h02;
  assign len2 = {2'h0, bt.ps2} + 5'h01;
  assign phase_err = cnt_q + 5'h01;
  // RULE23 late edge lengthens segment one
  assign len_one = !edge_q ? len_q :
    len_q + ((phase_err < jump) ? phase_err : jump);
  assign len_two = edge_q ? len_q - jump : len_q;
  assign at_sample = seg_q == SEG_ONE && cnt_q + 5'h01 == len_one;

  // RULE1 quantum prescaler
  always_ff @(posedge clock) begin
    if (rst || !bt.run || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // an edge between quanta is kept for the next one; set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_prev_q <= 1'b1;
      edge_q <= 1'b0;
    end else begin
      rx_prev_q <= bt.rx;
      if (rx_prev_q && !bt.rx) begin
        edge_q <= 1'b1;
      end else if (tick) begin
        edge_q <= 1'b0;
      end
    end
  end

  // RULE22 sync, then segment one, then segment two
  always_ff @(posedge clock) begin
    if (rst || !bt.run) begin
      seg_q <= SEG_SYNC;
      cnt_q <= 5'h00;
      len_q <= 5'h00;
    end else if (tick) begin
      case (seg_q)
        SEG_SYNC: begin
          seg_q <= SEG_ONE;
          cnt_q <= 5'h00;
          len_q <= len1;
        end
        SEG_ONE: begin
          if (at_sample) begin
            seg_q <= SEG_TWO;
            cnt_q <= 5'h00;
            len_q <= len2;
          end else begin
            cnt_q <= cnt_q + 5'h01;
            len_q <= len_one;
          end
        end
        SEG_TWO: begin
          // RULE23 early edge shortens or restarts
          if (edge_q && len_q - cnt_q <= jump) begin
            seg_q <= SEG_ONE;
            cnt_q <= 5'h00;
            len_q <= len1;
          end else if (cnt_q + 5'h01 >= len_two) begin
            seg_q <= SEG_SYNC;
            cnt_q <= 5'h00;
          end else begin
            cnt_q <= cnt_q + 5'h01;
            len_q <= len_two;
          end
        end
        default: seg_q <= SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tq_q <= 1'b0;
      sample_q <= 1'b0;
      bit_q <= 1'b1;
      txp_q <= 1'b0;
    end else begin
      tq_q <= tick;
      sample_q <= tick && at_sample;
      if (tick && at_sample) begin
        bit_q <= bt.rx;
      end
      // RULE4 one quantum late when segment two field is two
      txp_q <= tick && (bt.ps2 == PS2_LATE_TX ?
        (seg_q == SEG_ONE && cnt_q == 5'h00) : seg_q == SEG_SYNC);
    end
  end

  assign bt.tq_en = tq_q;
  assign bt.sample = sample_q;
  assign bt.rx_bit = bit_q;
  assign bt.tx_point = txp_q;

  a_quantum_rate: assert property ( // RULE1
    @(posedge clock) disable iff (rst)
    tick && bt.prescale == 8'h01 && $stable(bt.prescale)
    |=> !tick ##1 tick)
    else $error("quantum not every second clock");
  a_late_tx: assert property ( // RULE4
    @(posedge clock) disable iff (rst)
    tick && seg_q == SEG_SYNC && bt.ps2 == PS2_LATE_TX |=> !txp_q)
    else $error("tx point not delayed one quantum");
endmodule

// file: can_bit_timing_fault_confinement.sv
// Summary of operation
// RULE1 - quantum clock is system clock divided by the 8-bit prescaler
// RULE2 - software never sets segment two to zero at one clock per quantum
// RULE3 - processing time is three quanta at one clock, two otherwise
// RULE4 - segment two field of two moves transmit one quantum late
// RULE5 - under ten clocks per bit, early start of frame may beat us
// RULE6 - software keeps a bit time at nine clocks or more
// RULE7 - two 8-bit counters: up by 8 or 1, down by 1, floor 0
// RULE8 - counters writable only in test, freeze or halt
// RULE9 - either counter at 128 or more gives error passive
// RULE10 - both counters at 127 or less return to error active
// RULE11 - transmit count beyond 255 gives bus off and clears it
// RULE12 - bus off counts 128 runs of 11 recessive bits, then active
// RULE13 - dominant bit before 11 recessive clears the run counter
// RULE14 - receive count above 127 holds, then loads preset on success
// RULE15 - flags by state, suspend when passive, silent when bus off
// RULE16 - lone node acknowledge errors reach passive but never bus off
// RULE17 - software initialises modes, timing, prescaler, buffers, masks
// RULE18 - software sets interrupt level then per-source masks
// RULE19 - clearing halt last starts synchronising to the bus
// RULE20 - software deactivates a buffer before preparing it
// RULE21 - bus off and error flags in status, masks in pin mode
// RULE22 - bit is sync plus propagation, phase one and phase two
// RULE23 - resynchronise by at most the jump width on falling edges
//
// The plain strobed port and the address map were chosen for this implementation.
module can_bit_timing_fault_confinement
  import can_pkg::*;
#(
  parameter logic [7:0] RX_LOAD = RX_PRESET_MIN
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  // bus pins
  input wire logic rx_pin,
  output logic tx_pin_q,
  // protocol engine requests and events
  input wire logic tx_bit,
  input wire logic flag_bit,
  input wire logic tx_err_ev,
  input wire logic tx_ack_err_ev,
  input wire logic tx_ok_ev,
  input wire logic tx_end_ev,
  input wire logic rx_err_ev,
  input wire logic rx_err8_ev,
  input wire logic rx_ok_ev,
  // timing and state to the protocol engine
  output logic sample_q,
  output logic rx_bit_q,
  output logic tx_point_q,
  output logic tx_permit_q,
  output fault_state_t fault_confinement_state_q,
  // masked interrupt requests
  output logic busoff_req_q,
  output logic error_req_q
);
  if (RX_LOAD < RX_PRESET_MIN || RX_LOAD > RX_PRESET_MAX) begin : g_chk
    $error("RX_LOAD outside the receive preset range");
  end

  logic [7:0] pin_mode_control_q;
  logic [7:0] timing_control_one_q;
  logic [7:0] timing_control_two_q;
  logic [7:0] quantum_prescaler_q;
  logic [7:0] module_config_register_q;
  logic [7:0] transmit_error_counter_q;
  logic [7:0] transmit_error_counter_d;
  logic [7:0] receive_error_counter_q;
  logic [7:0] receive_error_counter_d;
  fault_state_t state_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic [3:0] suspend_q;
  logic busoff_flag_q;
  logic error_flag_q;
  logic rx_meta_q;
  logic rx_sync_q;
  logic running;
  logic count_wr;
  logic busoff_ev;
  logic passive_ev;
  logic status_wr;
  logic [8:0] tx_up;
  logic [1:0] info_processing_time;
  logic [4:0] bit_quanta;
  logic [12:0] bit_clocks;
  logic [7:0] status_word;

  can_bt_if bt();

  can_bit_timing u_timing (
    .clock(clock),
    .rst(rst),
    .bt(bt.timing)
  );

  // RULE19 halt clear lets the timing run
  assign running = !module_config_register_q[MCR_HALT];
  assign bt.run = running;
  assign bt.prescale = quantum_prescaler_q;
  assign bt.prop = timing_control_one_q[C1_PROP_LSB +: 3];
  assign bt.ps1 = timing_control_two_q[C2_PS1_LSB +: 3];
  assign bt.ps2 = timing_control_two_q[C2_PS2_LSB +: 3];
  assign bt.jump_width = timing_control_two_q[C2_JUMP_LSB +: 2];
  assign bt.rx = rx_sync_q;
  assign sample_q = bt.sample;
  assign rx_bit_q = bt.rx_bit;
  assign tx_point_q = bt.tx_point;

  // RULE8 counter writes only while stopped or testing
  assign count_wr = module_config_register_q[MCR_HALT] ||
    module_config_register_q[MCR_FREEZE] ||
    module_config_register_q[MCR_TEST];
  assign status_wr = wr && addr == A_ERR_STATUS;

  // RULE3 processing time from the prescaler
  assign info_processing_time = quantum_prescaler_q == 8'h00 ?
    PROC_ONE_CLOCK : PROC_OTHER;
  assign bit_quanta = {2'h0, bt.prop} + {2'h0, bt.ps1} +
    {2'h0, bt.ps2} + 5'h04;
  // RULE5 short bits are only reported, arbitration may be missed
  assign bit_clocks = 13'(({5'h00, quantum_prescaler_q} + 13'h0001) *
    {8'h00, bit_quanta});

  // bus level crosses in from the pin
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // configuration registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_mode_control_q <= REG_RESET;
      timing_control_one_q <= REG_RESET;
      timing_control_two_q <= REG_RESET;
      quantum_prescaler_q <= REG_RESET;
      module_config_register_q <= MCR_RESET;
    end else if (wr) begin
      case (addr)
        A_PIN_MODE: pin_mode_control_q <= wdata;
        A_TIMING_ONE: timing_control_one_q <= wdata;
        A_TIMING_TWO: timing_control_two_q <= wdata;
        A_PRESCALER: quantum_prescaler_q <= wdata;
        A_MODULE_CFG: module_config_register_q <= wdata;
        default: ;
      endcase
    end
  end

  // error counting and state transitions
  always_comb begin
    transmit_error_counter_d = transmit_error_counter_q;
    receive_error_counter_d = receive_error_counter_q;
    state_d = fault_confinement_state_q;
    run_d = run_q;
    busoff_ev = 1'b0;
    tx_up = {1'b0, transmit_error_counter_q} + {1'b0, ERR_STEP};
    if (fault_confinement_state_q == BUS_OFF) begin
      if (bt.sample) begin
        if (!bt.rx_bit) begin
          // RULE13 dominant bit restarts the run only
          run_d = 4'h0;
        end else if (run_q == RUN_LAST_BIT) begin
          // RULE12 eleven recessive bits make one run
          run_d = 4'h0;
          transmit_error_counter_d = transmit_error_counter_q + 8'h01;
          if (transmit_error_counter_d == RECOVERY_RUNS) begin
            state_d = ERR_ACTIVE;
            transmit_error_counter_d = 8'h00;
            receive_error_counter_d = 8'h00;
          end
        end else begin
          run_d = run_q + 4'h1;
        end
      end
    end else begin
      // RULE16 passive node ignores acknowledge errors
      if (tx_err_ev ||
          (tx_ack_err_ev && fault_confinement_state_q == ERR_ACTIVE)) begin
        // RULE11 overflow means bus off
        if (tx_up[8]) begin
          state_d = BUS_OFF;
          transmit_error_counter_d = 8'h00;
          busoff_ev = 1'b1;
        end else begin
          // RULE7 step of eight
          transmit_error_counter_d = tx_up[7:0];
        end
      end else if (tx_ok_ev && transmit_error_counter_q != 8'h00) begin
        transmit_error_counter_d = transmit_error_counter_q - 8'h01;
      end
      // RULE14 hold at or above passive level, preset on success
      if (receive_error_counter_q > ACTIVE_LEVEL) begin
        if (rx_ok_ev) begin
          receive_error_counter_d = RX_LOAD;
        end
      end else if (rx_err8_ev) begin
        receive_error_counter_d = receive_error_counter_q + ERR_STEP;
      end else if (rx_err_ev) begin
        receive_error_counter_d = receive_error_counter_q + 8'h01;
      end else if (rx_ok_ev && receive_error_counter_q != 8'h00) begin
        // RULE7 never below zero
        receive_error_counter_d = receive_error_counter_q - 8'h01;
      end
    end
    // RULE8 software load overrides while allowed
    if (wr && count_wr && addr == A_TX_COUNT) begin
      transmit_error_counter_d = wdata;
    end
    if (wr && count_wr && addr == A_RX_COUNT) begin
      receive_error_counter_d = wdata;
    end
    // RULE9 RULE10 passive and active levels
    if (state_d != BUS_OFF) begin
      if (transmit_error_counter_d >= PASSIVE_LEVEL ||
          receive_error_counter_d >= PASSIVE_LEVEL) begin
        state_d = ERR_PASSIVE;
      end else begin
        state_d = ERR_ACTIVE;
      end
    end
    passive_ev = fault_confinement_state_q == ERR_ACTIVE &&
      state_d == ERR_PASSIVE;
  end

  // RULE7 counters clear at reset
  always_ff @(posedge clock) begin
    if (rst) begin
      transmit_error_counter_q <= 8'h00;
      receive_error_counter_q <= 8'h00;
      fault_confinement_state_q <= ERR_ACTIVE;
      run_q <= 4'h0;
    end else begin
      transmit_error_counter_q <= transmit_error_counter_d;
      receive_error_counter_q <= receive_error_counter_d;
      fault_confinement_state_q <= state_d;
      run_q <= run_d;
    end
  end

  // RULE21 sticky flags, write one to clear, a new event wins
  always_ff @(posedge clock) begin
    if (rst) begin
      busoff_flag_q <= 1'b0;
      error_flag_q <= 1'b0;
      busoff_req_q <= 1'b0;
      error_req_q <= 1'b0;
    end else begin
      busoff_flag_q <= busoff_ev ||
        (busoff_flag_q && !(status_wr && wdata[ES_BUSOFF]));
      error_flag_q <= passive_ev ||
        (error_flag_q && !(status_wr && wdata[ES_ERROR]));
      busoff_req_q <= busoff_flag_q && pin_mode_control_q[C0_BUSOFF_MASK];
      error_req_q <= error_flag_q && pin_mode_control_q[C0_ERROR_MASK];
    end
  end

  // RULE15 silent when bus off, passive flags stay recessive
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_pin_q <= 1'b1;
    end else if (fault_confinement_state_q == BUS_OFF || !running) begin
      tx_pin_q <= 1'b1;
    end else if (bt.tx_point) begin
      tx_pin_q <= (flag_bit &&
        fault_confinement_state_q == ERR_PASSIVE) ? 1'b1 : tx_bit;
    end
  end

  // RULE15 passive transmitter waits eight bits after its frame
  always_ff @(posedge clock) begin
    if (rst) begin
      suspend_q <= 4'h0;
      tx_permit_q <= 1'b0;
    end else begin
      if (tx_end_ev && fault_confinement_state_q == ERR_PASSIVE) begin
        suspend_q <= SUSPEND_BITS;
      end else if (bt.sample && suspend_q != 4'h0) begin
        suspend_q <= suspend_q - 4'h1;
      end
      tx_permit_q <= running && suspend_q == 4'h0 &&
        fault_confinement_state_q != BUS_OFF;
    end
  end

  always_comb begin
    status_word = 8'h00;
    status_word[ES_PROC_LSB +: 2] = info_processing_time;
    status_word[ES_STATE_LSB +: 2] = fault_confinement_state_q;
    status_word[ES_SLOW] = bit_clocks < SLOW_BIT_CLOCKS;
    status_word[ES_BUSOFF] = busoff_flag_q;
    status_word[ES_ERROR] = error_flag_q;
  end

  // read data only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst || !rd) begin
      rdata_q <= 8'h00;
    end else begin
      case (addr)
        A_PIN_MODE: rdata_q <= pin_mode_control_q;
        A_TIMING_ONE: rdata_q <= timing_control_one_q;
        A_TIMING_TWO: rdata_q <= timing_control_two_q;
        A_PRESCALER: rdata_q <= quantum_prescaler_q;
        A_MODULE_CFG: rdata_q <= module_config_register_q;
        A_ERR_STATUS: rdata_q <= status_word;
        A_TX_COUNT: rdata_q <= transmit_error_counter_q;
        A_RX_COUNT: rdata_q <= receive_error_counter_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_busoff_entry: assert property ( // RULE11
    fault_confinement_state_q != BUS_OFF && tx_err_ev &&
    transmit_error_counter_q > 8'hf7 && !(wr && count_wr)
    |=> fault_confinement_state_q == BUS_OFF &&
    transmit_error_counter_q == 8'h00 ##1 busoff_flag_q)
    else $error("overflow did not give bus off");
  a_passive_level: assert property ( // RULE9
    fault_confinement_state_q != BUS_OFF &&
    (transmit_error_counter_q > 8'h7f || receive_error_counter_q > 8'h7f)
    |-> fault_confinement_state_q == ERR_PASSIVE)
    else $error("count at 128 but not passive");
  a_active_return: assert property ( // RULE10
    fault_confinement_state_q != BUS_OFF &&
    transmit_error_counter_q < 8'h80 && receive_error_counter_q < 8'h80
    |-> fault_confinement_state_q == ERR_ACTIVE)
    else $error("counts low but not active");
  a_rx_hold: assert property ( // RULE14
    fault_confinement_state_q != BUS_OFF &&
    receive_error_counter_q > 8'h7f && !rx_ok_ev && !(wr && count_wr)
    |=> $stable(receive_error_counter_q))
    else $error("receive count moved above 127");
  // a high transmit count keeps the node passive after the preset
  a_rx_preset: assert property ( // RULE14
    fault_confinement_state_q != BUS_OFF &&
    receive_error_counter_q > 8'h7f && rx_ok_ev && !(wr && count_wr) &&
    transmit_error_counter_q < 8'h80 && !tx_err_ev && !tx_ack_err_ev
    |=> receive_error_counter_q == RX_LOAD &&
    fault_confinement_state_q != ERR_PASSIVE)
    else $error("receive count not preset");
  a_lone_ack: assert property ( // RULE16
    fault_confinement_state_q == ERR_PASSIVE && tx_ack_err_ev &&
    !tx_err_ev && !tx_ok_ev && !(wr && count_wr)
    |=> fault_confinement_state_q != BUS_OFF &&
    $stable(transmit_error_counter_q))
    else $error("acknowledge error counted while passive");
  a_run_clear: assert property ( // RULE13
    fault_confinement_state_q == BUS_OFF && bt.sample &&
    !bt.rx_bit && !(wr && count_wr)
    |=> run_q == 4'h0 && $stable(transmit_error_counter_q))
    else $error("dominant bit changed the count");
  a_recovery: assert property ( // RULE12
    fault_confinement_state_q == BUS_OFF && bt.sample &&
    bt.rx_bit && run_q == 4'ha &&
    transmit_error_counter_q == 8'h7f && !(wr && count_wr)
    |=> fault_confinement_state_q == ERR_ACTIVE &&
    transmit_error_counter_q == 8'h00 && receive_error_counter_q == 8'h00)
    else $error("recovery did not end bus off");
  a_busoff_silent: assert property ( // RULE15
    fault_confinement_state_q == BUS_OFF |=> tx_pin_q && !tx_permit_q)
    else $error("bus off node drives the bus");
  a_count_ro: assert property ( // RULE8
    wr && !count_wr && addr == A_TX_COUNT && !tx_err_ev && !tx_ok_ev &&
    !tx_ack_err_ev && fault_confinement_state_q != BUS_OFF
    |=> $stable(transmit_error_counter_q))
    else $error("counter written outside halt");
  a_proc_time: assert property ( // RULE3
    rd && addr == A_ERR_STATUS && quantum_prescaler_q == 8'h00
    |=> rdata_q[7:6] == 2'h3)
    else $error("processing time not three quanta");

  c_busoff: cover property (fault_confinement_state_q == BUS_OFF);
  c_passive_back: cover property (
    fault_confinement_state_q == ERR_PASSIVE ##1
    fault_confinement_state_q == ERR_ACTIVE);
  c_recovered: cover property (
    fault_confinement_state_q == BUS_OFF ##1
    fault_confinement_state_q == ERR_ACTIVE);
endmodule

// file: can_bus_node.sv
module can_bus_node (
  // clock and bus
  input wire logic clock,
  input wire logic tx_pin,
  // other nodes pull dominant when told
  input wire logic dom,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired-and: any dominant driver wins the bus
  always_ff @(posedge clock) rx_pin <= tx_pin & ~dom;
endmodule

// file: can_bit_timing_fault_confinement_tb_top.sv
module can_bit_timing_fault_confinement_tb_top
  import can_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, dom = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata_q;
  logic [6:0] ev = 7'h00;
  logic rx_pin, tx_pin_q, sample_q, boreq, ereq, permit;
  fault_state_t st;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hbb35;
  int mismatches = 0, n_compared = 0, cyc = 0, low_n = 0, n;
  always #4 clock = ~clock;
  can_bus_node can_bus_node_i (.clock(clock), .tx_pin(tx_pin_q), .dom(dom),
    .rx_pin(rx_pin));
  can_bit_timing_fault_confinement can_bit_timing_fault_confinement_i (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .rx_pin(rx_pin), .tx_pin_q(tx_pin_q), .tx_bit(1'b0),
    .flag_bit(1'b0), .tx_err_ev(ev[0]), .tx_ack_err_ev(ev[1]),
    .tx_ok_ev(ev[2]), .tx_end_ev(ev[3]), .rx_err_ev(ev[4]),
    .rx_err8_ev(ev[5]), .rx_ok_ev(ev[6]), .sample_q(sample_q),
    .rx_bit_q(), .tx_point_q(), .tx_permit_q(permit),
    .fault_confinement_state_q(st), .busoff_req_q(boreq),
    .error_req_q(ereq));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(logic [7:0] g, logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic put(logic [3:0] a, logic [7:0] d);
    wr <= 1;
    addr <= a;
    wdata <= d;
    tick(1);
    wr <= 0;
    tick(1);
  endtask
  task automatic get(logic [3:0] a, logic [7:0] e);
    rd <= 1;
    addr <= a;
    exp_q.push_back(e);
    tick(1);
    rd <= 0;
    tick(1);
  endtask
  task automatic pulse(int i);
    ev[i] <= 1;
    tick(1);
    ev <= 7'h00;
    tick(3);
  endtask
  task automatic chk_st(fault_state_t e);
    chk({6'h00, st}, {6'h00, e});
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    rd_d <= rd;
    if (rd_d) chk(rdata_q, exp_q.pop_front());
  end
  // bus off must never pull the bus dominant, though tx_bit asks it
  always @(posedge clock) begin
    cyc++;
    if (st === BUS_OFF && tx_pin_q !== 1'b1) low_n++;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    tick(12);
    rst <= 0;
    tick(1);
    get(A_ERR_STATUS, 8'hc8);
    seed = lfsr(seed);
    put(A_PIN_MODE, seed[7:0]);
    get(A_PIN_MODE, seed[7:0]);
    put(A_PIN_MODE, 8'hc0);
    put(A_TIMING_ONE, 8'h02);
    put(A_TIMING_TWO, 8'h11);
    put(A_PRESCALER, 8'h00);
    put(A_TIMING_ONE, 8'h82);
    get(A_ERR_STATUS, 8'hc8);
    put(A_TX_COUNT, 8'hf8);
    get(A_TX_COUNT, 8'hf8);
    get(A_ERR_STATUS, 8'hda);
    chk({5'h00, boreq, ereq, permit}, 8'h02);
    put(A_ERR_STATUS, 8'h02);
    pulse(0);
    chk_st(BUS_OFF);
    get(A_ERR_STATUS, 8'hec);
    get(A_TX_COUNT, 8'h00);
    chk({5'h00, boreq, ereq, permit}, 8'h04);
    $display("test confinement done");
    put(A_MODULE_CFG, 8'h00);
    tick(120);
    dom <= 1;
    tick(18);
    dom <= 0;
    get(A_TX_COUNT, 8'h01);
    tick(12250);
    chk_st(BUS_OFF);
    tick(1100);
    chk_st(ERR_ACTIVE);
    get(A_TX_COUNT, 8'h00);
    chk({7'h00, low_n != 0}, 8'h00);
    $display("test recovery done");
    for (n = 0; n < 20; n++) pulse(1);
    get(A_TX_COUNT, 8'h80);
    chk_st(ERR_PASSIVE);
    pulse(3);
    chk({5'h00, boreq, ereq, permit}, 8'h06);
    tick(100);
    chk({5'h00, boreq, ereq, permit}, 8'h07);
    for (n = 0; n < 17; n++) pulse(5);
    get(A_RX_COUNT, 8'h80);
    pulse(2);
    chk_st(ERR_PASSIVE);
    pulse(6);
    get(A_RX_COUNT, RX_PRESET_MIN);
    chk_st(ERR_ACTIVE);
    pulse(4);
    get(A_RX_COUNT, 8'h78);
    put(A_TX_COUNT, 8'h55);
    get(A_TX_COUNT, 8'h7f);
    $display("test counters done");
    conclude();
  end
endmodule
